/* hw/spx_lookup.sv */
// Segment lookup: priority match over all descriptors and address widening.
// Assumes descriptor state is held by the top and given as a flat array.
`timescale 1ns/1ps
module spx_lookup (
   input wire spx_pkg::spx_seg_type segs [spx_pkg::NUM_SEG],
   spx_match_if.unit m
);
   function automatic logic [31:0] size_mask(input logic [4:0] size);
      logic [31:0] mk;
      mk = 32'hffff_ffff << (size + 5'h01);
      if (size == spx_pkg::SIZE_4GB) begin
         mk = 32'h0000_0000;
      end
      return mk;
   endfunction

   always_comb begin
      logic [31:0] mk;
      logic [31:0] base_full;
      logic [35:0] repl_full;
      mk = 32'h0;
      base_full = 32'h0;
      repl_full = 36'h0;
      m.hit = 1'b0;
      m.index = 4'h0;
      m.permission_byte = 8'h00;
      m.phys = {4'h0, m.addr};
      m.ctrl_range = (m.addr <= spx_pkg::CTRL_RANGE_TOP);
      if (!m.ctrl_range) begin
         for (int i = 0; i < spx_pkg::NUM_SEG; i++) begin
            mk = size_mask(segs[i].size);
            base_full = {segs[i].base, 12'h000};
            repl_full = {segs[i].repl, 12'h000};
            // Later winners overwrite earlier ones, so the highest index wins.
            if (segs[i].size >= spx_pkg::SIZE_MIN &&
                ((m.addr & mk) == (base_full & mk))) begin
               m.hit = 1'b1;
               m.index = 4'(i);
               m.permission_byte = segs[i].permission_byte;
               m.phys = (repl_full & {4'hf, mk}) | {4'h0, m.addr & ~mk};
            end
         end
      end
   end
endmodule // spx_lookup

/* hw/spx_match_if.sv */
// Carries one segment lookup between the lookup unit and its top.
// Assumes the user drives addr and reads the result combinationally.
`timescale 1ns/1ps
interface spx_match_if;
   logic [31:0] addr;
   logic hit;
   logic [3:0] index;
   logic [35:0] phys;
   logic [7:0] permission_byte;
   logic ctrl_range;
   modport user (output addr, input hit, index, phys, permission_byte, ctrl_range);
   modport unit (input addr, output hit, index, phys, permission_byte, ctrl_range);
endinterface

/* hw/spx_pkg.sv */
// Package for the segment protect and extend unit: register map, field layout, reset values.
// Assumes a 100 MHz controller clock and a plain address/strobe register port.
package spx_pkg;
   localparam int unsigned NUM_SEG = 16;
   localparam logic [7:0] OFS_SEG_BASE = 8'h00;
   localparam logic [7:0] OFS_FAULT_ADDR = 8'h80;
   localparam logic [7:0] OFS_FAULT_STAT = 8'h84;
   localparam logic [7:0] OFS_FAULT_CLR = 8'h88;
   localparam logic [4:0] SIZE_DISABLED = 5'h00;
   localparam logic [4:0] SIZE_MIN = 5'h0b;
   localparam logic [4:0] SIZE_4GB = 5'h1f;
   localparam logic [4:0] SIZE_2GB = 5'h1e;
   localparam int unsigned HI_BASE_LSB = 12;
   localparam int unsigned HI_SIZE_LSB = 0;
   localparam int unsigned LO_REPL_LSB = 8;
   localparam int unsigned FAULT_LOCAL_BIT = 8;
   localparam int unsigned FAULT_CLEAR_BIT = 0;
   localparam logic [31:0] CTRL_RANGE_TOP = 32'h0bff_ffff;
   localparam logic [7:0] PERMISSION_BYTE_ALL = 8'h3f;
   localparam logic [19:0] SEG0_BASE_RST = 20'h00000;
   localparam logic [19:0] SEG1_BASE_RST = 20'h80000;
   localparam logic [23:0] SEG0_REPL_RST = 24'h000000;
   localparam logic [23:0] SEG1_REPL_RST = 24'h080000;
   localparam logic [31:0] FAULT_RST = 32'h0000_0000;
   // Access type bit positions within the 6-bit access code.
   localparam int unsigned ACC_SR = 5;
   localparam int unsigned ACC_SW = 4;
   localparam int unsigned ACC_SX = 3;
   localparam int unsigned ACC_UR = 2;
   localparam int unsigned ACC_UW = 1;
   localparam int unsigned ACC_UX = 0;

   typedef struct packed {
      logic [19:0] base;
      logic [4:0] size;
      logic [23:0] repl;
      logic [7:0] permission_byte;
   } spx_seg_type;
endpackage

/* hw/spx_top.sv */
// Segment protect and extend unit top: descriptors, request check, fault capture.
// Assumes requests arrive from same-clock cache logic as one-cycle valid pulses.
`timescale 1ns/1ps
// How it works
// - Reset clears segments two through fifteen.
// - Segments zero, one reset as pass-through halves.
// - Segments are aligned power-of-two regions.
// - Hit compares upper bits per size code.
// - Size 4GB hits every address.
// - Highest numbered hitting segment wins.
// - No hit means no permission, fault unless cacheable.
// - Control range bypasses segments, zero-extended.
// - Own registers are supervisor-only.
// - Immediate violations captured and raise exception.
// - Cacheable accesses return permissions, cache checks.
// - Replacement bits widen address to 36.
// - Only the first fault is captured.
// - Writing one to bit zero clears capture.
// - Upper bits of clear write ignored.
// - Fault address readable, resets to zero.
// - Status holds local flag and access type.
// - Five bit size code, small codes disabled.
// - Low word holds replacement and permissions.
// - Permission bits order supervisor then user.
module spx_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_sup,
   output logic [31:0] reg_rdata,
   output logic reg_err,
   input wire logic req_valid,
   input wire logic [31:0] req_addr,
   input wire logic [5:0] req_type,
   input wire logic req_cacheable,
   input wire logic req_local,
   output logic rsp_valid,
   output logic [35:0] rsp_phys,
   output logic [7:0] rsp_permission_byte,
   output logic rsp_deferred,
   output logic rsp_denied,
   output logic fault_exc
);
   typedef struct packed {
      spx_pkg::spx_seg_type [spx_pkg::NUM_SEG-1:0] seg;
      logic [31:0] fault_addr;
      logic [31:0] fault_stat;
      logic fault_full;
      logic [31:0] rdata;
      logic rerr;
      logic rsp_v;
      logic [35:0] phys;
      logic [7:0] permission_byte;
      logic deferred;
      logic denied;
      logic exc;
   } spx_state_type;

   spx_state_type st;
   spx_state_type next_st;
   spx_pkg::spx_seg_type seg_arr [spx_pkg::NUM_SEG];
   spx_match_if m ();

   always_comb begin
      for (int i = 0; i < spx_pkg::NUM_SEG; i++) begin
         seg_arr[i] = st.seg[i];
      end
   end

   assign m.addr = req_addr;

   spx_lookup u_lookup (
      .segs(seg_arr),
      .m(m)
   );

   function automatic spx_state_type reset_state();
      spx_state_type s;
      s = '0;
      s.seg[0].base = spx_pkg::SEG0_BASE_RST;
      s.seg[0].size = spx_pkg::SIZE_2GB;
      s.seg[0].repl = spx_pkg::SEG0_REPL_RST;
      s.seg[0].permission_byte = spx_pkg::PERMISSION_BYTE_ALL;
      s.seg[1].base = spx_pkg::SEG1_BASE_RST;
      s.seg[1].size = spx_pkg::SIZE_2GB;
      s.seg[1].repl = spx_pkg::SEG1_REPL_RST;
      s.seg[1].permission_byte = spx_pkg::PERMISSION_BYTE_ALL;
      s.fault_addr = spx_pkg::FAULT_RST;
      s.fault_stat = spx_pkg::FAULT_RST;
      return s;
   endfunction

   // The access type is a one-hot request; it is allowed if it is non-zero and every requested bit is granted.
   function automatic logic granted(input logic [5:0] typ, input logic [7:0] permission_byte);
      return ((typ & ~permission_byte[5:0]) == 6'h00) && (typ != 6'h00);
   endfunction

   always_comb begin
      logic [3:0] idx;
      logic is_seg;
      logic violation;
      idx = reg_addr[6:3];
      is_seg = (reg_addr < spx_pkg::OFS_FAULT_ADDR);
      violation = 1'b0;
      next_st = st;
      next_st.rsp_v = 1'b0;
      next_st.exc = 1'b0;
      next_st.rerr = 1'b0;
      next_st.rdata = 32'h0;
      // Register writes: descriptors need supervisor mode, status registers are read-only.
      if (reg_wr) begin
         if (!reg_sup) begin
            next_st.rerr = 1'b1;
         end else if (is_seg && reg_addr[1:0] == 2'b00) begin
            if (reg_addr[2]) begin
               next_st.seg[idx].base = reg_wdata[31:spx_pkg::HI_BASE_LSB];
               next_st.seg[idx].size = reg_wdata[spx_pkg::HI_SIZE_LSB +: 5];
            end else begin
               next_st.seg[idx].repl = reg_wdata[31:spx_pkg::LO_REPL_LSB];
               next_st.seg[idx].permission_byte = reg_wdata[7:0];
            end
         end else if (reg_addr == spx_pkg::OFS_FAULT_CLR) begin
            if (reg_wdata[spx_pkg::FAULT_CLEAR_BIT]) begin
               next_st.fault_full = 1'b0;
               next_st.fault_addr = spx_pkg::FAULT_RST;
               next_st.fault_stat = spx_pkg::FAULT_RST;
            end
         end else begin
            next_st.rerr = 1'b1;
         end
      end
      if (reg_rd) begin
         if (!reg_sup) begin
            next_st.rerr = 1'b1;
         end else if (is_seg && reg_addr[1:0] == 2'b00) begin
            if (reg_addr[2]) begin
               next_st.rdata = {st.seg[idx].base, 7'h00, st.seg[idx].size};
            end else begin
               next_st.rdata = {st.seg[idx].repl, st.seg[idx].permission_byte};
            end
         end else if (reg_addr == spx_pkg::OFS_FAULT_ADDR) begin
            next_st.rdata = st.fault_addr;
         end else if (reg_addr == spx_pkg::OFS_FAULT_STAT) begin
            next_st.rdata = st.fault_stat;
         end else if (reg_addr != spx_pkg::OFS_FAULT_CLR) begin
            next_st.rerr = 1'b1;
         end
      end
      // Request path: answer one cycle after the request.
      if (req_valid) begin
         next_st.rsp_v = 1'b1;
         next_st.phys = m.phys;
         next_st.permission_byte = m.hit ? m.permission_byte : 8'h00;
         next_st.deferred = 1'b0;
         next_st.denied = 1'b0;
         if (m.ctrl_range) begin
            next_st.permission_byte = spx_pkg::PERMISSION_BYTE_ALL;
         end else if (req_cacheable) begin
            next_st.deferred = 1'b1;
         end else begin
            violation = !m.hit || !granted(req_type, m.permission_byte);
            next_st.denied = violation;
         end
         // A clear in the same cycle loses to a fresh fault so the event is kept.
         if (violation && (!st.fault_full || next_st.fault_full == 1'b0 && st.fault_full)) begin
            next_st.fault_full = 1'b1;
            next_st.fault_addr = req_addr;
            next_st.fault_stat = {23'h0, req_local, 2'b00, req_type};
            next_st.exc = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= reset_state();
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign reg_err = st.rerr;
   assign rsp_valid = st.rsp_v;
   assign rsp_phys = st.phys;
   assign rsp_permission_byte = st.permission_byte;
   assign rsp_deferred = st.deferred;
   assign rsp_denied = st.denied;
   assign fault_exc = st.exc;

   // Second, independent hit map for the checks: a shift compare instead of a mask.
   function automatic logic seg_covers(input spx_pkg::spx_seg_type sg, input logic [31:0] a);
      logic [5:0] sh;
      sh = {1'b0, sg.size} + 6'h01;
      return (sg.size >= spx_pkg::SIZE_MIN) && ((a >> sh) == ({sg.base, 12'h000} >> sh));
   endfunction

   logic [spx_pkg::NUM_SEG-1:0] hit_vec;

   always_comb begin
      for (int i = 0; i < spx_pkg::NUM_SEG; i++) begin
         hit_vec[i] = seg_covers(st.seg[i], req_addr);
      end
   end

   sequence s_reset_done;
      $past(srst) && !srst;
   endsequence

   sequence s_imm_req;
      req_valid && !req_cacheable && !m.ctrl_range && m.hit;
   endsequence

   sequence s_imm_denied;
      s_imm_req ##0 ((req_type & ~m.permission_byte[5:0]) != 6'h00);
   endsequence

   sequence s_imm_granted;
      s_imm_req ##0 (req_type != 6'h00 && (req_type & ~m.permission_byte[5:0]) == 6'h00);
   endsequence

   sequence s_fault_req;
      req_valid && !req_cacheable && !m.ctrl_range && !m.hit && !st.fault_full;
   endsequence

   AST_NOHIT_FAULT: assert property (@(posedge clk) disable iff (srst)
      s_fault_req |=> fault_exc && rsp_denied && (rsp_permission_byte == 8'h00))
      else $error("Unmatched request did not fault.");
   AST_ONE_FAULT: assert property (@(posedge clk) disable iff (srst)
      st.fault_full && !reg_wr |=> !fault_exc && $stable(st.fault_addr))
      else $error("Second fault overwrote capture.");
   AST_CLEAR: assert property (@(posedge clk) disable iff (srst)
      reg_wr && reg_sup && reg_addr == spx_pkg::OFS_FAULT_CLR && reg_wdata[0] && !req_valid
      |=> !st.fault_full && st.fault_addr == 32'h0)
      else $error("Clear did not erase capture.");
   AST_CLEAR_ZERO: assert property (@(posedge clk) disable iff (srst)
      st.fault_full && reg_wr && reg_addr == spx_pkg::OFS_FAULT_CLR && !reg_wdata[0]
      |=> st.fault_full)
      else $error("Writing zero cleared capture.");
   AST_CTRL_PASS: assert property (@(posedge clk) disable iff (srst)
      req_valid && req_addr <= spx_pkg::CTRL_RANGE_TOP
      |=> !rsp_denied && rsp_phys == {4'h0, $past(req_addr)})
      else $error("Control range access altered.");
   AST_DEFER: assert property (@(posedge clk) disable iff (srst)
      req_valid && req_cacheable && !m.ctrl_range |=> rsp_deferred && !fault_exc)
      else $error("Cacheable access not deferred.");
   AST_RESP_TIME: assert property (@(posedge clk) disable iff (srst)
      req_valid |=> rsp_valid ##1 (!rsp_valid || $past(req_valid)))
      else $error("Response timing wrong.");
   AST_CAPTURE_ADDR: assert property (@(posedge clk) disable iff (srst)
      fault_exc |-> st.fault_addr == $past(req_addr) && st.fault_stat[31:9] == 23'h0)
      else $error("Captured address mismatch.");
   AST_USER_REG: assert property (@(posedge clk) disable iff (srst)
      (reg_wr || reg_rd) && !reg_sup |=> reg_err)
      else $error("User register access not refused.");

   // Further checks on reset, lookup, widening, grants, fault capture and registers.
   AST_RESET_LOW: assert property (@(posedge clk) disable iff (srst)
      s_reset_done |-> st.seg[0].size == spx_pkg::SIZE_2GB && st.seg[1].repl ==
      spx_pkg::SEG1_REPL_RST && st.seg[0].permission_byte == spx_pkg::PERMISSION_BYTE_ALL)
      else $error("Low segments not preloaded.");

   AST_RESET_HIGH: assert property (@(posedge clk) disable iff (srst)
      s_reset_done |-> st.seg[2] == '0 && st.seg[15] == '0 && !st.fault_full)
      else $error("Upper segments not cleared.");

   AST_RESET_OUT: assert property (@(posedge clk) disable iff (srst)
      s_reset_done |-> st.fault_addr == 32'h0 && !rsp_valid && !fault_exc &&
      reg_rdata == 32'h0)
      else $error("Outputs not idle after reset.");

   AST_NO_DISABLED_WIN: assert property (@(posedge clk) disable iff (srst)
      m.hit |-> seg_arr[m.index].size >= spx_pkg::SIZE_MIN)
      else $error("Disabled segment won the lookup.");

   AST_PRIORITY: assert property (@(posedge clk) disable iff (srst)
      req_valid && !m.ctrl_range |-> m.hit == (hit_vec != '0) &&
      (hit_vec >> m.index) <= 16'h0001)
      else $error("Winner is not the highest hitting segment.");

   AST_LOW_BITS: assert property (@(posedge clk) disable iff (srst)
      req_valid |=> rsp_phys[11:0] == $past(req_addr[11:0]))
      else $error("Offset bits inside a segment changed.");

   AST_WIDEN: assert property (@(posedge clk) disable iff (srst)
      req_valid && m.hit
      |=> rsp_phys[35:32] == $past(seg_arr[m.index].repl[23:20]))
      else $error("Upper physical bits not from replacement.");

   AST_DENY: assert property (@(posedge clk) disable iff (srst)
      s_imm_denied |=> rsp_denied)
      else $error("Missing grant not denied.");

   AST_GRANT: assert property (@(posedge clk) disable iff (srst)
      s_imm_granted |=> !rsp_denied && !fault_exc)
      else $error("Granted access denied.");

   AST_TYPE_ZERO: assert property (@(posedge clk) disable iff (srst)
      req_valid && !req_cacheable && !m.ctrl_range && req_type == 6'h00
      |=> rsp_denied)
      else $error("Empty access type not denied.");

   AST_STAT_ZERO: assert property (@(posedge clk) disable iff (srst)
      st.fault_stat[31:9] == 23'h0 && st.fault_stat[7:6] == 2'b00)
      else $error("Reserved status bits set.");

   AST_CAPTURE_STAT: assert property (@(posedge clk) disable iff (srst)
      fault_exc |-> st.fault_stat[8] == $past(req_local) &&
      st.fault_stat[5:0] == $past(req_type))
      else $error("Captured status mismatch.");

   AST_RISE_EXC: assert property (@(posedge clk) disable iff (srst)
      $rose(st.fault_full) |-> fault_exc)
      else $error("Capture filled without exception.");

   AST_CLEAR_UPPER: assert property (@(posedge clk) disable iff (srst)
      st.fault_full && reg_wr && reg_addr == spx_pkg::OFS_FAULT_CLR && !reg_wdata[0]
      |=> $stable(st.fault_stat))
      else $error("Upper clear bits changed capture.");

   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (srst)
      !reg_rd |=> reg_rdata == 32'h0)
      else $error("Read data without read strobe.");

   AST_FAULT_RO: assert property (@(posedge clk) disable iff (srst)
      reg_wr && !req_valid && (reg_addr == spx_pkg::OFS_FAULT_ADDR ||
      reg_addr == spx_pkg::OFS_FAULT_STAT) |=> reg_err && $stable(st.fault_addr))
      else $error("Capture register was writable.");

   AST_IDLE_RSP: assert property (@(posedge clk) disable iff (srst)
      !req_valid |=> !rsp_valid && !fault_exc)
      else $error("Response without request.");

   AST_DEFER_PERMISSION_BYTE: assert property (@(posedge clk) disable iff (srst)
      req_valid && req_cacheable && m.hit
      |=> rsp_permission_byte == $past(m.permission_byte) && !rsp_denied)
      else $error("Deferred permissions not returned.");
endmodule // spx_top

/* test/spx_core_model.sv */
// Core and cache side model: sends one request, keeps the reply, judges deferred grants.
// Assumes the unit answers exactly one cycle after each request pulse.
`timescale 1ns/1ps
module spx_core_model (
   input wire logic clk,
   output logic req_valid,
   output logic [31:0] req_addr,
   output logic [5:0] req_type,
   output logic req_cacheable,
   output logic req_local,
   input wire logic rsp_valid,
   input wire logic [35:0] rsp_phys,
   input wire logic [7:0] rsp_permission_byte,
   input wire logic rsp_deferred,
   input wire logic rsp_denied,
   input wire logic fault_exc
);
   logic [47:0] got;
   logic cache_deny;
   initial begin
      req_valid = 1'b0;
      req_addr = 32'h0;
      req_type = 6'h0;
      req_cacheable = 1'b0;
      req_local = 1'b0;
   end
   task automatic issue(input logic [31:0] a, input logic [5:0] t, input logic c, input logic l);
      // The core serves its own low window and never sends it out.
      if (a < 32'h0800_0000) return;
      @(posedge clk);
      req_valid <= 1'b1;
      req_addr <= a;
      req_type <= t;
      req_cacheable <= c;
      req_local <= l;
      @(posedge clk);
      req_valid <= 1'b0;
      // Released address and type lines are inverted so that a stale value cannot pass for a held one.
      req_addr <= ~a;
      req_type <= ~t;
      #1;
      got = {rsp_valid, rsp_denied, rsp_deferred, fault_exc, rsp_permission_byte, rsp_phys};
      cache_deny = rsp_deferred && ((rsp_permission_byte[5:0] & t) == 6'h0);
   endtask
endmodule // spx_core_model

/* test/tb_top.sv */
// Self-checking bench for the segment protect and extend unit.
// Assumes the core model owns the request link and the bench owns the register port.
`timescale 1ns/1ps
module tb_top;
   logic clk, srst, reg_wr, reg_rd, reg_sup, reg_err;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, req_addr;
   logic req_valid, req_cacheable, req_local, rsp_valid, rsp_deferred, rsp_denied, fault_exc;
   logic [5:0] req_type;
   logic [35:0] rsp_phys;
   logic [7:0] rsp_permission_byte;
   int err_total = 0;
   int compares = 0;
   spx_top DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sup(reg_sup), .reg_rdata(reg_rdata),
      .reg_err(reg_err), .req_valid(req_valid), .req_addr(req_addr), .req_type(req_type),
      .req_cacheable(req_cacheable), .req_local(req_local), .rsp_valid(rsp_valid),
      .rsp_phys(rsp_phys), .rsp_permission_byte(rsp_permission_byte), .rsp_deferred(rsp_deferred),
      .rsp_denied(rsp_denied), .fault_exc(fault_exc));
   spx_core_model core (.clk(clk), .req_valid(req_valid), .req_addr(req_addr),
      .req_type(req_type), .req_cacheable(req_cacheable), .req_local(req_local),
      .rsp_valid(rsp_valid), .rsp_phys(rsp_phys), .rsp_permission_byte(rsp_permission_byte),
      .rsp_deferred(rsp_deferred), .rsp_denied(rsp_denied), .fault_exc(fault_exc));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic s,
                      input logic [32:0] e);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      reg_sup <= s;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      // Read data stand only in this cycle; after a write they must read zero.
      chk({15'h0, reg_err, reg_rdata}, {15'h0, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b1, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 1'b1, {1'b0, e});
   endtask
   task automatic seg(input logic [4:0] n, input logic [19:0] b, input logic [4:0] sz,
                      input logic [23:0] r, input logic [7:0] p);
      wr({n, 3'h4}, {b, 7'h0, sz});
      wr({n, 3'h0}, {r, p});
   endtask
   // Physical address is judged only on requests that are not denied.
   task automatic rq(input logic [31:0] a, input logic [5:0] t, input logic c, input logic l,
                     input logic [47:0] e);
      core.issue(a, t, c, l);
      chk({core.got[47:36], core.got[46] ? 36'h0 : core.got[35:0]}, e);
   endtask
   task automatic t_reset();
      rd(8'h80, 32'h0);
      rd(8'h84, 32'h0);
      rd(8'h00, 32'h0000_003f);
      rd(8'h04, 32'h0000_001e);
      rd(8'h08, 32'h0800_003f);
      rd(8'h0c, 32'h8000_001e);
      rd(8'h10, 32'h0);
      rd(8'h7c, 32'h0);
      rq(32'h9000_1234, 6'h20, 1'b0, 1'b0, {4'h8, 8'h3f, 36'h0_9000_1234});
      $display("test reset done");
   endtask
   task automatic t_xlate();
      logic den;
      logic cap;
      cap = 1'b0;
      seg(5'd2, 20'hc0007, 5'h0b, 24'h150042, 8'h20);
      rq(32'hc000_7abc, 6'h20, 1'b0, 1'b0, {4'h8, 8'h20, 36'h1_5004_2abc});
      rq(32'hc000_8abc, 6'h20, 1'b0, 1'b0, {4'h8, 8'h3f, 36'h0_c000_8abc});
      seg(5'd3, 20'ha1345, 5'h17, 24'h7a2000, 8'h3f);
      rq(32'ha1ff_fff0, 6'h10, 1'b0, 1'b0, {4'h8, 8'h3f, 36'h7_a2ff_fff0});
      rq(32'ha200_0010, 6'h10, 1'b0, 1'b0, {4'h8, 8'h3f, 36'h0_a200_0010});
      seg(5'd4, 20'h12345, 5'h1f, 24'h3fffff, 8'h3f);
      rq(32'h4000_0100, 6'h01, 1'b0, 1'b0, {4'h8, 8'h3f, 36'h3_4000_0100});
      wr(8'h24, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(8'h10, {24'h150042, 8'h01 << i});
         for (int j = 0; j < 6; j++) begin
            den = (i != j);
            rq(32'hc000_7abc, 6'h01 << j, 1'b0, 1'b0, {1'b1, den, 1'b0, den & !cap,
               8'h01 << i, den ? 36'h0 : 36'h1_5004_2abc});
            cap = cap | den;
         end
      end
      wr(8'h88, 32'h1);
      wr(8'h10, {24'h150042, 8'h20});
      $display("test translate done");
   endtask
   task automatic t_fault();
      wr(8'h0c, 32'h8000_000a);
      rq(32'h9000_0040, 6'h02, 1'b0, 1'b1, {4'hd, 8'h00, 36'h0});
      rd(8'h80, 32'h9000_0040);
      rd(8'h84, 32'h0000_0102);
      rq(32'h9000_0080, 6'h04, 1'b0, 1'b0, {4'hc, 8'h00, 36'h0});
      rd(8'h80, 32'h9000_0040);
      wr(8'h88, 32'hffff_fffe);
      rd(8'h84, 32'h0000_0102);
      wr(8'h88, 32'h1);
      rd(8'h80, 32'h0);
      rq(32'h9000_0080, 6'h04, 1'b0, 1'b0, {4'hd, 8'h00, 36'h0});
      rd(8'h84, 32'h0000_0004);
      wr(8'h88, 32'h1);
      wr(8'h0c, 32'h8000_001e);
      $display("test fault done");
   endtask
   task automatic t_ctrl();
      seg(5'd5, 20'h00000, 5'h1b, 24'hfff000, 8'h00);
      rq(32'h0bff_fffc, 6'h02, 1'b0, 1'b0, {4'h8, 8'h3f, 36'h0_0bff_fffc});
      rq(32'h0c00_0000, 6'h02, 1'b0, 1'b0, {4'hd, 8'h00, 36'h0});
      wr(8'h88, 32'h1);
      wr(8'h2c, 32'h0);
      $display("test control range done");
   endtask
   task automatic t_cache();
      rq(32'hc000_7abc, 6'h10, 1'b1, 1'b0, {4'ha, 8'h20, 36'h1_5004_2abc});
      chk({47'h0, core.cache_deny}, {47'h0, 1'b1});
      rq(32'hc000_7abc, 6'h20, 1'b1, 1'b0, {4'ha, 8'h20, 36'h1_5004_2abc});
      chk({47'h0, core.cache_deny}, {47'h0, 1'b0});
      $display("test cache done");
   endtask
   task automatic t_regs();
      bus(1'b0, 8'h00, 32'h0, 1'b0, {1'b1, 32'h0});
      bus(1'b1, 8'h10, 32'hffff_ffff, 1'b0, {1'b1, 32'h0});
      rd(8'h10, 32'h1500_4220);
      bus(1'b1, 8'h80, 32'h1234_5678, 1'b1, {1'b1, 32'h0});
      bus(1'b1, 8'h84, 32'h1, 1'b1, {1'b1, 32'h0});
      bus(1'b0, 8'hfc, 32'h0, 1'b1, {1'b1, 32'h0});
      rd(8'h80, 32'h0);
      $display("test registers done");
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end
   initial begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_sup = 1'b1;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_xlate();
      t_fault();
      t_ctrl();
      t_cache();
      t_regs();
      tally_and_finish();
   end
endmodule // tb_top
